/* File: core/alrs_conv.v */
`include "alrs_regs.vh"

module alrs_conv #(
   parameter [23:0] CONV_CYC  = `ALRS_CONV_CYC,
   parameter [23:0] FRAME_CYC = `ALRS_FRAME_CYC
) (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // control
   input  wire        enable,
   input  wire        cont,
   input  wire [2:0]  avg_exp,
   // photodiode sample
   input  wire [15:0] sample,
   // result
   output reg         busy_q,
   output reg         done_q,
   output reg  [15:0] result_q
);

   // ====================================================================
   // states
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_CONV = 2'd1;
   localparam [1:0] ST_WAIT = 2'd2;

   reg [1:0]  st_q;
   reg [23:0] frame_q;
   reg [23:0] conv_q;
   reg [7:0]  n_q;
   reg [22:0] sum_q;
   reg        cont_q;
   reg [2:0]  exp_q;
   wire [22:0] sum_d;

   // shift divide: the count is always a power of two
   function [15:0] avg;
      input [22:0] s;
      input [2:0]  e;
      reg   [22:0] t;
      begin
         t   = s >> e;
         avg = t[15:0];
      end
   endfunction

   assign sum_d = sum_q + {7'h00, sample};

   // ====================================================================
   // frame and conversion sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= ST_IDLE;
         frame_q  <= 24'h000000;
         conv_q   <= 24'h000000;
         n_q      <= 8'h00;
         sum_q    <= 23'h000000;
         cont_q   <= 1'b0;
         exp_q    <= 3'h0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         result_q <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               // settings latched per frame so a mid-frame write cannot skew it
               if (enable) begin
                  st_q    <= ST_CONV;
                  frame_q <= 24'h000000;
                  conv_q  <= 24'h000000;
                  n_q     <= 8'h00;
                  sum_q   <= 23'h000000;
                  cont_q  <= cont;
                  exp_q   <= avg_exp;
                  busy_q  <= 1'b1;
               end
            end
            ST_CONV: begin
               frame_q <= frame_q + 24'h000001;
               if (conv_q == CONV_CYC - 24'h000001) begin
                  conv_q <= 24'h000000;
                  sum_q  <= sum_d;
                  n_q    <= n_q + 8'h01;
                  if (n_q == (8'h01 << exp_q) - 8'h01) begin
                     busy_q <= 1'b0;
                     if (cont_q) begin
                        result_q <= avg(sum_d, exp_q);
                        done_q   <= 1'b1;
                        st_q     <= ST_IDLE;
                     end else begin
                        st_q <= ST_WAIT;
                     end
                  end
               end else begin
                  conv_q <= conv_q + 24'h000001;
               end
            end
            ST_WAIT: begin
               frame_q <= frame_q + 24'h000001;
               if (frame_q == FRAME_CYC - 24'h000001) begin
                  result_q <= avg(sum_q, exp_q);
                  done_q   <= 1'b1;
                  st_q     <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

endmodule

/* File: core/alrs_top.v */
`include "alrs_regs.vh"

module alrs_top #(
   parameter [23:0] CONV_CYC  = `ALRS_CONV_CYC,
   parameter [23:0] FRAME_CYC = `ALRS_FRAME_CYC
) (
   // clock and reset
   input  wire        CLK,
   input  wire        RST_N,
   // two-wire bus, data pin split three ways
   input  wire        SCL,
   input  wire        SDA_I,
   output reg         SDA_O,
   output reg         SDA_OE,
   // photodiode converter
   input  wire [15:0] ALS_SAMPLE,
   output reg         ALS_BUSY
);

   // ====================================================================
   // reset release
   reg rst_s1_q;
   reg rst_s2_q;
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_n = rst_s2_q;

   // ====================================================================
   // state codes and storage
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ADDR = 3'd1;
   localparam [2:0] ST_ACK  = 3'd2;
   localparam [2:0] ST_WR   = 3'd3;
   localparam [2:0] ST_RD   = 3'd4;
   localparam [2:0] ST_HACK = 3'd5;

   reg [2:0]  st_q;
   reg [3:0]  bitc_q;
   reg [7:0]  sr_q;
   reg [7:0]  tx_q;
   reg [7:0]  ptr_q;
   reg        rw_q;
   reg        first_q;
   reg        hack_q;
   reg        scl_q;
   reg        sda_q;
   reg        scl_p_q;
   reg        sda_p_q;
   reg [7:0]  cmd_q;
   reg [7:0]  cfg_q;
   reg [15:0] res_q;
   reg [7:0]  snap_lo_q;
   reg        rdy_q;

   wire        conv_busy;
   wire        conv_done;
   wire [15:0] conv_res;

   // ====================================================================
   // bus line edges
   wire scl_rise = scl_q & ~scl_p_q;
   wire scl_fall = ~scl_q & scl_p_q;
   wire start_c  = scl_q & scl_p_q & sda_p_q & ~sda_q;
   wire stop_c   = scl_q & scl_p_q & ~sda_p_q & sda_q;

   // register read multiplexer, unmapped indices read zero
   function [7:0] rd_mux;
      input [7:0]  idx;
      input [7:0]  cmd;
      input        rdy;
      input [7:0]  cfg;
      input [15:0] res;
      input [7:0]  lo;
      begin
         case (idx)
            `ALRS_REG_CMD:    rd_mux = {cmd[7], rdy, cmd[5:0]};
            `ALRS_REG_CFG:    rd_mux = cfg;
            `ALRS_REG_RES_HI: rd_mux = res[15:8];
            `ALRS_REG_RES_LO: rd_mux = lo;
            default:          rd_mux = 8'h00;
         endcase
      end
   endfunction

   wire [7:0] rd_byte = rd_mux(ptr_q, cmd_q, rdy_q, cfg_q, res_q, snap_lo_q);
   wire       rd_hi   = (ptr_q == `ALRS_REG_RES_HI);

   // ====================================================================
   // bus slave
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= ST_IDLE;
         bitc_q    <= 4'h0;
         sr_q      <= 8'h00;
         tx_q      <= 8'h00;
         ptr_q     <= 8'h00;
         rw_q      <= 1'b0;
         first_q   <= 1'b0;
         hack_q    <= 1'b0;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         scl_p_q   <= 1'b1;
         sda_p_q   <= 1'b1;
         cmd_q     <= `ALRS_CMD_RST;
         cfg_q     <= `ALRS_CFG_RST;
         res_q     <= 16'h0000;
         snap_lo_q <= 8'h00;
         rdy_q     <= 1'b0;
         SDA_O     <= 1'b0;
         SDA_OE    <= 1'b0;
         ALS_BUSY  <= 1'b0;
      end else begin
         scl_q    <= SCL;
         sda_q    <= SDA_I;
         scl_p_q  <= scl_q;
         sda_p_q  <= sda_q;
         ALS_BUSY <= conv_busy;
         // new result wins over the clear caused by a high-byte read
         if (conv_done) begin
            res_q <= conv_res;
            rdy_q <= 1'b1;
         end
         if (start_c) begin
            // a repeated start lands here as well, pointer kept
            st_q   <= ST_ADDR;
            bitc_q <= 4'h0;
            SDA_OE <= 1'b0;
         end else if (stop_c) begin
            st_q   <= ST_IDLE;
            SDA_OE <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: SDA_OE <= 1'b0;
               ST_ADDR, ST_WR: begin
                  if (scl_rise) begin
                     sr_q   <= {sr_q[6:0], sda_q};
                     bitc_q <= bitc_q + 4'h1;
                  end else if (scl_fall && bitc_q == 4'h8) begin
                     bitc_q <= 4'h0;
                     if (st_q == ST_ADDR) begin
                        if (sr_q[7:1] == `ALRS_DEV_ADDR) begin
                           rw_q    <= sr_q[0];
                           first_q <= ~sr_q[0];
                           st_q    <= ST_ACK;
                           SDA_OE  <= 1'b1;
                        end else begin
                           st_q <= ST_IDLE;
                        end
                     end else begin
                        first_q <= 1'b0;
                        st_q    <= ST_ACK;
                        SDA_OE  <= 1'b1;
                        if (first_q) begin
                           ptr_q <= sr_q;
                        end else begin
                           ptr_q <= ptr_q + 8'h01;
                           if (ptr_q == `ALRS_REG_CMD) begin
                              cmd_q <= sr_q;
                           end
                           if (ptr_q == `ALRS_REG_CFG) begin
                              cfg_q <= sr_q;
                           end
                        end
                     end
                  end
               end
               ST_ACK, ST_HACK: begin
                  if (scl_rise) begin
                     hack_q <= ~sda_q;
                  end else if (scl_fall) begin
                     bitc_q <= 4'h0;
                     if (st_q == ST_ACK && !rw_q) begin
                        st_q   <= ST_WR;
                        SDA_OE <= 1'b0;
                     end else if (st_q == ST_ACK || hack_q) begin
                        // high-byte read snapshots the low byte against tearing
                        tx_q   <= rd_byte;
                        SDA_OE <= ~rd_byte[7];
                        st_q   <= ST_RD;
                        if (rd_hi) begin
                           snap_lo_q <= res_q[7:0];
                           if (!conv_done) begin
                              rdy_q <= 1'b0;
                           end
                        end
                     end else begin
                        st_q   <= ST_IDLE;  // host nack, wait for stop
                        SDA_OE <= 1'b0;
                     end
                  end
               end
               ST_RD: begin
                  if (scl_rise) begin
                     bitc_q <= bitc_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bitc_q == 4'h8) begin
                        SDA_OE <= 1'b0;
                        st_q   <= ST_HACK;
                        ptr_q  <= ptr_q + 8'h01;
                     end else begin
                        tx_q   <= {tx_q[6:0], 1'b0};
                        SDA_OE <= ~tx_q[6];
                     end
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // ====================================================================
   // ambient conversion sequencer
   alrs_conv #(
      .CONV_CYC  (CONV_CYC),
      .FRAME_CYC (FRAME_CYC)
   ) u_conv (
      .clk      (CLK),
      .rst_n    (rst_n),
      .enable   (cmd_q[`ALRS_CMD_EN_BIT]),
      .cont     (cfg_q[`ALRS_CFG_CONT_BIT]),
      .avg_exp  (cfg_q[2:0]),
      .sample   (ALS_SAMPLE),
      .busy_q   (conv_busy),
      .done_q   (conv_done),
      .result_q (conv_res)
   );

endmodule

/* File: shared/alrs_regs.vh */
// Function
// - each returned read byte advances the register pointer by one
// - read address byte returns the register the pointer selects; after the result high byte, the next read returns the low byte
// - ambient config bit 7 clear selects standard, set selects continuous mode
// - standard mode fits the whole averaged measurement into a 100 ms frame
// - every single conversion lasts about 300 us in either mode
// - configured count of conversions, up to 128, is averaged into the result
// - standard mode publishes the result only when the 100 ms frame ends
// - continuous mode starts each conversion right after the previous one
// - stop plus start or repeated start both accepted between write and read
`ifndef ALRS_REGS_VH
`define ALRS_REGS_VH

// ====================================================================
// bus addressing
`define ALRS_DEV_ADDR      7'h13
`define ALRS_REG_CMD       8'h80
`define ALRS_REG_CFG       8'h84
`define ALRS_REG_RES_HI    8'h85
`define ALRS_REG_RES_LO    8'h86

// ====================================================================
// field positions and reset values
`define ALRS_CMD_EN_BIT    2
`define ALRS_CMD_RDY_BIT   6
`define ALRS_CFG_CONT_BIT  7
`define ALRS_CMD_RST       8'h00
`define ALRS_CFG_RST       8'h00

// ====================================================================
// timing
`define ALRS_CLK_MHZ       100
`define ALRS_CONV_TIME_US  300
`define ALRS_FRAME_TIME_MS 100
// the same two times as cycle counts at 100 MHz, sized for the 24-bit counters
`define ALRS_CONV_CYC      24'h007530
`define ALRS_FRAME_CYC     24'h989680

`endif

/* File: tb/alrs_host.sv */
module alrs_host (
   // bus side
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   parameter int HALF = 10;
   // idle bus: clock stands high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // ========
   // one half period of the bus clock, moved just past the edge
   task automatic hp();
      repeat (HALF) @(posedge clk);
      #1;
   endtask
   // start and repeated start share one path
   task automatic start();
      sda_oe = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_oe = 1'b1;
      hp();
      scl = 1'b0;
      hp();
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_oe = 1'b0;
      hp();
   endtask
   // data set while clock low, sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_oe = ~b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      scl = 1'b0;
      hp();
   endtask
   // msb first, ninth slot is the acknowledge
   task automatic xfer(input logic [7:0] w, output logic [7:0] r,
                       input logic a_in, output logic a_out);
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(a_in, a_out);
   endtask
endmodule

/* File: tb/alrs_properties.sv */
module alrs_properties #(
   parameter int CONV_CYC  = 4,
   parameter int FRAME_CYC = 64
) (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST_N,
   // bus pins
   input wire logic        SCL,
   input wire logic        SDA_I,
   input wire logic        SDA_O,
   input wire logic        SDA_OE,
   // converter
   input wire logic [15:0] ALS_SAMPLE,
   input wire logic        ALS_BUSY
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic [15:0] gap_q;
   logic [7:0]  low_q;
   logic        seen_q;
   // ========
   // busy counters, saturating so a long idle never wraps into a frame
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         gap_q <= 16'hffff;
         low_q <= 8'h00;
         seen_q <= 1'b0;
      end else begin
         gap_q <= $rose(ALS_BUSY) ? 16'h0001 : gap_q + {15'h0000, gap_q != 16'hffff};
         low_q <= ALS_BUSY ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
         seen_q <= seen_q | $rose(ALS_BUSY);
      end
   end
   // ========
   // steps of a conversion and of a bus answer
   sequence conv_pass;
      ALS_BUSY [*4];
   endsequence
   sequence scl_fell_late;
      !SCL && ($past(SCL, 2) || $past(SCL, 3) || $past(SCL, 4) || $past(SCL, 5));
   endsequence
   // ========
   // bus pin
   odrain_low_a: assert property (SDA_O == 1'b0)
      else $error("data pin driven high");
   oe_steady_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
      else $error("data drive moved while clock high");
   oe_answer_a: assert property ($changed(SDA_OE) |-> scl_fell_late)
      else $error("data drive changed outside its slot");
   oe_lag_a: assert property ($fell(SCL) |=> $stable(SDA_OE))
      else $error("data drive changed too early");
   start_free_a: assert property (SCL && $fell(SDA_I) |-> !SDA_OE)
      else $error("device pulled data at a start");
   // ========
   // conversion timing
   conv_min_a: assert property ($rose(ALS_BUSY) |-> conv_pass)
      else $error("conversion shorter than one sample");
   run_max_a: assert property ($fell(ALS_BUSY) |-> gap_q inside {[CONV_CYC:128*CONV_CYC+2]})
      else $error("conversion run length out of range");
   frame_gap_a: assert property ($rose(ALS_BUSY) && seen_q && low_q > 8'h03 |->
      gap_q inside {[FRAME_CYC:FRAME_CYC+1]})
      else $error("standard frame period wrong");
endmodule

/* File: tb/tb_top.sv */
`define CHK(n, e, s) begin \
   num_checks++; \
   if ((s) !== (e)) begin \
      bad_count++; \
      $display("wrong value %s exp %h got %h", n, e, s); \
   end \
end

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CONV = 4;
   localparam int FRAME = 64;
   logic        clk;
   logic        rst_n;
   logic [15:0] sample;
   logic        scl;
   logic        host_oe;
   logic        sda_o;
   logic        sda_oe;
   logic        busy;
   wire         sda;
   int          bad_count;
   int          num_checks;
   logic [7:0]  hi;
   logic [7:0]  lo;
   logic        ack;
   // open-drain data wire with pull-up
   assign sda = (host_oe || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
   alrs_top #(.CONV_CYC(24'h000004), .FRAME_CYC(24'h000040)) alrs_top_i (.CLK(clk), .RST_N(rst_n),
      .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ALS_SAMPLE(sample),
      .ALS_BUSY(busy));
   alrs_host alrs_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ========
   // bus and wait helpers
   task automatic wait_lvl(input logic v);
      int n;
      n = 0;
      while (busy !== v && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 2000) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
      alrs_host_i.start();
      alrs_host_i.xfer(8'h26, hi, 1'b1, ack);
      alrs_host_i.xfer(idx, hi, 1'b1, ack);
      alrs_host_i.xfer(d, hi, 1'b1, ack);
      alrs_host_i.stop();
      `CHK("write ack", 1'b0, ack)
   endtask
   // address once, then two single-byte reads
   task automatic rd2(input logic [7:0] idx, input logic rs);
      alrs_host_i.start();
      alrs_host_i.xfer(8'h26, hi, 1'b1, ack);
      alrs_host_i.xfer(idx, hi, 1'b1, ack);
      `CHK("index ack", 1'b0, ack)
      if (!rs) alrs_host_i.stop();
      alrs_host_i.start();
      alrs_host_i.xfer(8'h27, hi, 1'b1, ack);
      alrs_host_i.xfer(8'hff, hi, 1'b1, ack);
      alrs_host_i.stop();
      alrs_host_i.start();
      alrs_host_i.xfer(8'h27, lo, 1'b1, ack);
      alrs_host_i.xfer(8'hff, lo, 1'b1, ack);
      alrs_host_i.stop();
   endtask
   // ========
   // scenarios
   task automatic t_reset();
      `CHK("busy idle", 1'b0, busy)
      rd2(8'h80, 1'b0);
      `CHK("cmd reset", 8'h00, hi)
      `CHK("unmapped", 8'h00, lo)
      rd2(8'h84, 1'b1);
      `CHK("cfg reset", 8'h00, hi)
      `CHK("result reset", 8'h00, lo)
      alrs_host_i.start();
      alrs_host_i.xfer(8'h30, hi, 1'b1, ack);
      alrs_host_i.stop();
      `CHK("foreign addr", 1'b1, ack)
      $display("t_reset done");
   endtask
   task automatic t_std();
      int n;
      wr_reg(8'h84, 8'h01);
      wr_reg(8'h80, 8'h04);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      n = 0;
      while (busy === 1'b1 && n < 600) begin
         @(posedge clk);
         #1;
         n++;
      end
      // a run that never ends is a hang, not just a wrong count
      if (n == 600) begin
         bad_count++;
         wrap_up();
      end
      `CHK("run cycles", 2 * CONV, n)
      rd2(8'h80, 1'b0);
      `CHK("ready", 8'h44, hi)
      rd2(8'h85, 1'b0);
      `CHK("std hi", 8'h12, hi)
      `CHK("std lo", 8'h34, lo)
      $display("t_std done");
   endtask
   task automatic t_cont();
      int lows;
      sample = 16'h5a3c;
      wr_reg(8'h84, 8'h83);
      repeat (FRAME) @(posedge clk);
      #1;
      lows = 0;
      for (int n = 0; n < 256; n++) begin
         @(posedge clk);
         #1;
         if (busy !== 1'b1) lows++;
      end
      `CHK("cont idle", 1'b1, lows <= 16)
      rd2(8'h85, 1'b1);
      `CHK("cont hi", 8'h5a, hi)
      `CHK("cont lo", 8'h3c, lo)
      rd2(8'h84, 1'b1);
      `CHK("cfg mode", 8'h83, hi)
      `CHK("next reg", 8'h5a, lo)
      $display("t_cont done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // reset for three cycles, then the scenarios in order
   initial begin
      rst_n = 1'b0;
      sample = 16'h1234;
      bad_count = 0;
      num_checks = 0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      t_reset();
      t_std();
      t_cont();
      wrap_up();
   end
endmodule

bind alrs_top alrs_properties #(.CONV_CYC(CONV_CYC), .FRAME_CYC(FRAME_CYC)) alrs_properties_i (
   .CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .ALS_SAMPLE(ALS_SAMPLE), .ALS_BUSY(ALS_BUSY));
